// ---- rtl/pcd_pkg.sv ----
// Package with register map, field layout, reset values and timing constants
package pcd_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register indices; byte address is four times the index
    localparam logic [15:0] IDX_DEV_RANGE   = 16'h2431;  // Deviation range setting
    localparam logic [15:0] IDX_COND_SEL    = 16'h2432;  // Completion condition select
    localparam logic [15:0] IDX_DELAY_TIME  = 16'h2433;  // Completion delay time, ms
    localparam logic [15:0] IDX_ZS_THRESH   = 16'h2434;  // Zero speed threshold, RPM
    localparam logic [15:0] IDX_OUT_CTRL    = 16'h2440;  // Output pin polarity control
    localparam logic [15:0] IDX_STATUS      = 16'h2441;  // Live status, read only

    ////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [15:0] RST_DEV_RANGE   = 16'h0014;  // 20 command units
    localparam logic [15:0] RST_COND_SEL    = 16'h0001;  // Condition 1
    localparam logic [15:0] RST_DELAY_TIME  = 16'h0000;  // No delay
    localparam logic [15:0] RST_ZS_THRESH   = 16'h0032;  // 50 RPM
    localparam logic        RST_NC_MODE     = 1'b0;      // Normally open

    ////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int OUT_CTRL_NC_BIT   = 0;  // 1 = normally closed assignment
    localparam int STAT_DONE_BIT     = 0;  // Completion flag
    localparam int STAT_ZS_BIT       = 1;  // Zero speed flag
    localparam int STAT_CMD_BIT      = 2;  // Position command active
    localparam int STAT_TIMER_BIT    = 3;  // Delay after command elapsed

    ////////////////////////////////////////////////////////////////////////////
    // Condition select codes
    localparam logic [15:0] COND_DEV_ONLY   = 16'h0000;
    localparam logic [15:0] COND_NO_CMD     = 16'h0001;
    localparam logic [15:0] COND_ZERO_SPD   = 16'h0002;
    localparam logic [15:0] COND_WINDOW     = 16'h0003;
    localparam logic [15:0] COND_DELAYED    = 16'h0004;

    ////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int          CLK_PERIOD_PS   = 4000;      // 250 MHz
    localparam int          MS_TIME_PS      = 1000000000; // One millisecond
    localparam int          MS_CYCLES       = MS_TIME_PS / CLK_PERIOD_PS;
    localparam logic [15:0] DELAY_MAX_MS    = 16'h3A98;  // 15000 ms
    localparam logic [15:0] ZS_HYST_RPM     = 16'h000A;  // 10 RPM hysteresis

    ////////////////////////////////////////////////////////////////////////////
    // Settings carried together
    typedef struct packed {
        logic [15:0] dev_range;
        logic [15:0] cond_sel;
        logic [15:0] delay_time;
        logic [15:0] zs_thresh;
        logic        nc_mode;
    } pcd_cfg_t;

    // Latched AHB address phase
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [29:0] word;
    } pcd_ahb_req_t;

endpackage

// ---- rtl/pcd_zero_speed.sv ----
// Zero speed detector with hysteresis, valid for either direction of rotation
module pcd_zero_speed #(
    parameter int SPD_W = 16
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    input  wire logic [SPD_W-1:0] i_speed,
    input  wire logic [15:0]      i_thresh,
    output logic                  o_zero_speed
);

    if (SPD_W < 2 || SPD_W > 32) begin : g_chk
        $error("SPD_W out of range");
    end

    logic [SPD_W-1:0] spd_mag;  // Magnitude of signed speed
    logic [32:0]      mag_ext;  // Magnitude widened for compare
    logic [32:0]      on_lvl;   // Below this the flag turns on
    logic [32:0]      off_lvl;  // At or above this the flag turns off
    logic             next_zero_speed;

    ////////////////////////////////////////////////////////////////////////////
    // Magnitude and hysteresis levels
    always_comb begin
        spd_mag = i_speed[SPD_W-1] ? SPD_W'(-i_speed) : i_speed;
        mag_ext = 33'(spd_mag);
        on_lvl  = 33'(i_thresh);
        off_lvl = 33'(i_thresh) + 33'(pcd_pkg::ZS_HYST_RPM);
    end

    // Next flag: on below threshold, off only past threshold plus hysteresis
    always_comb begin
        next_zero_speed = o_zero_speed;
        if (mag_ext < on_lvl) begin
            next_zero_speed = 1'b1;
        end else if (mag_ext >= off_lvl) begin
            next_zero_speed = 1'b0;
        end
    end

    // Flag register
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_zero_speed <= 1'b0;
        end else begin
            o_zero_speed <= next_zero_speed;
        end
    end

    // Inside the hysteresis band the flag keeps its last value
    a_zs_hyst: assert property (@(posedge i_clk) disable iff (i_rst)
        mag_ext >= on_lvl && mag_ext < off_lvl |=> $stable(o_zero_speed))
        else $error("Zero speed flag moved inside hysteresis band");

endmodule

// ---- rtl/pcd_top.sv ----
// Positioning completion detector with AHB-Lite register slave
//
// Behaviour
// - Settable deviation range, default twenty units
// - Condition select zero to four, default one
// - Condition 0: deviation below range only
// - Condition 1: no command and deviation in range
// - Condition 2: adds zero speed flag required
// - Condition 3: no command, in range, timed window
// - Condition 4: wait delay after commands, then check
// - Condition 3 delay zero holds flag until command
// - Zero speed flag with 10 RPM hysteresis
// - Pin active low open, active high closed
//
// Added by the designer: the AHB-Lite interface to the registers.
module pcd_top #(
    parameter int DEV_W     = 32,
    parameter int SPD_W     = 16,
    parameter int MS_CYCLES = pcd_pkg::MS_CYCLES
) (
    input  wire logic             I_REF_CLK,
    input  wire logic             I_SYS_RST,
    input  wire logic             HSEL,
    input  wire logic [31:0]      HADDR,
    input  wire logic [1:0]       HTRANS,
    input  wire logic             HWRITE,
    input  wire logic [2:0]       HSIZE,
    input  wire logic [31:0]      HWDATA,
    input  wire logic             HREADY,
    output logic      [31:0]      HRDATA,
    output logic                  HREADYOUT,
    output logic                  HRESP,
    input  wire logic [DEV_W-1:0] I_POS_DEVIATION,
    input  wire logic             I_POS_CMD_ACTIVE,
    input  wire logic [SPD_W-1:0] I_MOTOR_SPEED,
    output logic                  O_POSITIONING_DONE_FLAG,
    output logic                  O_COMPLETION_OUTPUT
);

    if (DEV_W < 17 || DEV_W > 32 || MS_CYCLES < 1 || MS_CYCLES > 16777215) begin : g_chk
        $error("Unsupported parameter value");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    pcd_pkg::pcd_cfg_t     cfg;           // Current settings
    pcd_pkg::pcd_cfg_t     next_cfg;
    pcd_pkg::pcd_ahb_req_t req;           // Address phase held for data phase
    pcd_pkg::pcd_ahb_req_t next_req;
    logic [31:0]           next_hrdata;
    logic [23:0]           div_cnt;       // Millisecond divider
    logic [23:0]           next_div_cnt;
    logic                  ms_tick;       // One-cycle millisecond enable
    logic                  next_ms_tick;
    logic [15:0]           ms_count;      // Milliseconds since command ceased
    logic [15:0]           next_ms_count;
    logic                  done;          // Completion flag
    logic                  next_done;
    logic                  pin;           // Pin level
    logic                  next_pin;
    logic                  zero_speed;    // From the zero speed detector
    logic [DEV_W-1:0]      dev_mag;       // Absolute deviation
    logic                  in_range;      // Deviation below range
    logic                  cmd_idle;      // No position command
    logic                  timer_done;    // Delay elapsed since command end
    logic [31:0]           status_word;   // Live state for software

    // Word address match for a register index
    function automatic logic hit(input logic [29:0] word, input logic [15:0] idx);
        hit = (word == 30'(idx));
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Zero speed detector
    pcd_zero_speed #(
        .SPD_W (SPD_W)
    ) u_zero_speed (
        .i_clk        (I_REF_CLK),
        .i_rst        (I_SYS_RST),
        .i_speed      (I_MOTOR_SPEED),
        .i_thresh     (cfg.zs_thresh),
        .o_zero_speed (zero_speed)
    );

    ////////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave: zero wait states, always OKAY
    assign HREADYOUT = 1'b1;
    assign HRESP     = 1'b0;

    // Status word for reads
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[pcd_pkg::STAT_DONE_BIT]  = done;
        status_word[pcd_pkg::STAT_ZS_BIT]    = zero_speed;
        status_word[pcd_pkg::STAT_CMD_BIT]   = I_POS_CMD_ACTIVE;
        status_word[pcd_pkg::STAT_TIMER_BIT] = timer_done;
    end

    // Next settings, address phase capture and read data
    always_comb begin
        next_cfg = cfg;
        next_req.valid = HSEL && HTRANS[1] && HREADY;
        next_req.write = HWRITE;
        next_req.word  = HADDR[31:2];
        // Data phase write; unmapped writes are dropped
        if (req.valid && req.write) begin
            if (hit(req.word, pcd_pkg::IDX_DEV_RANGE)) begin
                next_cfg.dev_range = HWDATA[15:0];
            end
            if (hit(req.word, pcd_pkg::IDX_COND_SEL)) begin
                next_cfg.cond_sel = HWDATA[15:0];
            end
            if (hit(req.word, pcd_pkg::IDX_DELAY_TIME)) begin
                next_cfg.delay_time = HWDATA[15:0];
            end
            if (hit(req.word, pcd_pkg::IDX_ZS_THRESH)) begin
                next_cfg.zs_thresh = HWDATA[15:0];
            end
            if (hit(req.word, pcd_pkg::IDX_OUT_CTRL)) begin
                next_cfg.nc_mode = HWDATA[pcd_pkg::OUT_CTRL_NC_BIT];
            end
        end
        // Read data from next settings so a write just before is seen
        next_hrdata = 32'h0000_0000;
        if (next_req.valid && !next_req.write) begin
            if (hit(next_req.word, pcd_pkg::IDX_DEV_RANGE)) begin
                next_hrdata = {16'h0000, next_cfg.dev_range};
            end else if (hit(next_req.word, pcd_pkg::IDX_COND_SEL)) begin
                next_hrdata = {16'h0000, next_cfg.cond_sel};
            end else if (hit(next_req.word, pcd_pkg::IDX_DELAY_TIME)) begin
                next_hrdata = {16'h0000, next_cfg.delay_time};
            end else if (hit(next_req.word, pcd_pkg::IDX_ZS_THRESH)) begin
                next_hrdata = {16'h0000, next_cfg.zs_thresh};
            end else if (hit(next_req.word, pcd_pkg::IDX_OUT_CTRL)) begin
                next_hrdata = {31'h0000_0000, next_cfg.nc_mode};
            end else if (hit(next_req.word, pcd_pkg::IDX_STATUS)) begin
                next_hrdata = status_word;
            end
        end
    end

    // Bus and settings registers
    always_ff @(posedge I_REF_CLK) begin
        if (I_SYS_RST) begin
            cfg.dev_range  <= pcd_pkg::RST_DEV_RANGE;
            cfg.cond_sel   <= pcd_pkg::RST_COND_SEL;
            cfg.delay_time <= pcd_pkg::RST_DELAY_TIME;
            cfg.zs_thresh  <= pcd_pkg::RST_ZS_THRESH;
            cfg.nc_mode    <= pcd_pkg::RST_NC_MODE;
            req            <= '0;
            HRDATA         <= 32'h0000_0000;
        end else begin
            cfg    <= next_cfg;
            req    <= next_req;
            HRDATA <= next_hrdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Millisecond divider and delay timer
    always_comb begin
        next_div_cnt  = div_cnt + 24'h00_0001;
        next_ms_tick  = 1'b0;
        if (div_cnt == 24'(MS_CYCLES - 1)) begin
            next_div_cnt = 24'h00_0000;
            next_ms_tick = 1'b1;
        end
        next_ms_count = ms_count;
        if (I_POS_CMD_ACTIVE) begin
            next_ms_count = 16'h0000;
        end else if (ms_tick && ms_count < pcd_pkg::DELAY_MAX_MS) begin
            next_ms_count = ms_count + 16'h0001;
        end
    end

    // Divider and timer registers
    always_ff @(posedge I_REF_CLK) begin
        if (I_SYS_RST) begin
            div_cnt  <= 24'h00_0000;
            ms_tick  <= 1'b0;
            ms_count <= 16'h0000;
        end else begin
            div_cnt  <= next_div_cnt;
            ms_tick  <= next_ms_tick;
            ms_count <= next_ms_count;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Completion decision
    always_comb begin
        dev_mag    = I_POS_DEVIATION[DEV_W-1] ? DEV_W'(-I_POS_DEVIATION) : I_POS_DEVIATION;
        in_range   = dev_mag < DEV_W'(cfg.dev_range);
        cmd_idle   = !I_POS_CMD_ACTIVE;
        timer_done = ms_count >= cfg.delay_time;
        next_done  = 1'b0;
        // Selected condition evaluated every cycle
        case (cfg.cond_sel)
            pcd_pkg::COND_DEV_ONLY: begin
                next_done = in_range;
            end
            pcd_pkg::COND_NO_CMD: begin
                next_done = cmd_idle && in_range;
            end
            pcd_pkg::COND_ZERO_SPD: begin
                next_done = cmd_idle && zero_speed && in_range;
            end
            pcd_pkg::COND_WINDOW: begin
                // Off through the delay, then held until the next command
                if (!cmd_idle) begin
                    next_done = 1'b0;
                end else if (done) begin
                    next_done = 1'b1;
                end else begin
                    next_done = in_range && timer_done;
                end
            end
            pcd_pkg::COND_DELAYED: begin
                next_done = cmd_idle && timer_done && in_range;
            end
            default: begin
                next_done = 1'b0;  // Out of range code keeps flag off
            end
        endcase
        // Normally open drives low when active, normally closed high
        next_pin = cfg.nc_mode ? next_done : !next_done;
    end

    // Flag and pin registers
    always_ff @(posedge I_REF_CLK) begin
        if (I_SYS_RST) begin
            done <= 1'b0;
            pin  <= 1'b1;
        end else begin
            done <= next_done;
            pin  <= next_pin;
        end
    end

    assign O_POSITIONING_DONE_FLAG = done;
    assign O_COMPLETION_OUTPUT     = pin;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (I_SYS_RST);

    a_range_reset: assert property ($rose(!I_SYS_RST) |-> cfg.dev_range == 16'h0014
        && cfg.cond_sel == 16'h0001) else $error("Setting reset values wrong");
    a_sel_write: assert property (req.valid && req.write && hit(req.word,
        pcd_pkg::IDX_COND_SEL) |=> cfg.cond_sel == $past(HWDATA[15:0]))
        else $error("Condition select write lost");
    a_mode0_in: assert property (cfg.cond_sel == 16'h0000 && in_range
        |=> done) else $error("Condition 0 flag missing");
    a_cmd_blocks: assert property (cfg.cond_sel != 16'h0000 && I_POS_CMD_ACTIVE
        |=> !done) else $error("Flag on during command");
    a_mode2_zs: assert property (cfg.cond_sel == 16'h0002 && !zero_speed
        |=> !done) else $error("Condition 2 flag without zero speed");
    a_out_range: assert property (cfg.cond_sel != 16'h0003 && !in_range
        |=> !done) else $error("Flag on with deviation out of range");
    a_delay_wait: assert property (cfg.cond_sel inside {16'h0003, 16'h0004}
        && ms_count < cfg.delay_time && !done |=> !done)
        else $error("Flag on before delay elapsed");
    a_window_hold: assert property (cfg.cond_sel == 16'h0003 && done
        && !I_POS_CMD_ACTIVE && $stable(cfg.cond_sel) |=> done)
        else $error("Condition 3 flag dropped without command");
    a_pin_level: assert property (pin == (cfg.nc_mode ? done : !done)
        || $changed(cfg.nc_mode)) else $error("Pin polarity wrong");
    a_bad_sel: assert property (cfg.cond_sel > 16'h0004 |=> !done)
        else $error("Illegal condition raised flag");
    a_timer_clear: assert property (I_POS_CMD_ACTIVE |=> (ms_count == 16'h0000)[*1])
        else $error("Delay timer not cleared by command");

    c_window_hold: cover property (cfg.cond_sel == 16'h0003 && done && !in_range);
    c_delayed_done: cover property (cfg.cond_sel == 16'h0004 && cfg.delay_time != 16'h0000
        && $rose(done));
    c_zero_speed: cover property (cfg.cond_sel == 16'h0002 && $rose(done));
    c_nc_pin: cover property (cfg.nc_mode && pin);

endmodule

// ---- verif/pcd_ctrl_model.sv ----
// Motion controller model that reads the completion pin
module pcd_ctrl_model (
    input  wire logic i_pin,
    input  wire logic i_nc,
    output logic      o_done_seen
);
    timeunit 1ns;
    timeprecision 1ps;

    // Pin is active low when normally open, active high when closed
    assign o_done_seen = i_nc ? i_pin : !i_pin;
endmodule

// ---- verif/tb.sv ----
// Self-checking bench for the positioning completion detector
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    ////////////////////////////////////////
    localparam int MSC   = 4;      // Short millisecond for simulation
    localparam int LIMIT = 20000;  // Cycle ceiling for the whole run
    logic        clk, rst, hsel, hwrite, hready, hresp, cmd, flag, pin, seen;
    logic [31:0] haddr, hwdata, hrdata, dev, seed;
    logic [1:0]  htrans;   // Transfer type
    logic [15:0] spd;      // Motor speed
    int          failures, comparisons, cycles;
    // Reference model: settings, zero speed, latch, expected flag (2 = unsure)
    int          m_range, m_cond, m_delay, m_nc, m_pnc, m_zs, m_lat, m_flag, cyc;

    ////////////////////////////////////////
    pcd_top #(.MS_CYCLES(MSC)) u_pcd_top (
        .I_REF_CLK(clk), .I_SYS_RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready),
        .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp), .I_POS_DEVIATION(dev),
        .I_POS_CMD_ACTIVE(cmd), .I_MOTOR_SPEED(spd), .O_POSITIONING_DONE_FLAG(flag),
        .O_COMPLETION_OUTPUT(pin)
    );
    pcd_ctrl_model u_pcd_ctrl_model (.i_pin(pin), .i_nc(m_pnc[0]), .o_done_seen(seen));

    // Free-running reference clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    ////////////////////////////////////////
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic chk_bit(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: flag %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: read %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic results();
        $display("Counts: %0d comparisons, %0d failures", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // One single word transfer; entered just after a rising edge
    task automatic bus(input logic [15:0] idx, input logic wr, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr  <= {14'h0, idx, 2'h0};
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= wd;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask

    // Write and mirror the stored setting into the model
    task automatic wr(input logic [15:0] idx, input logic [31:0] d);
        logic [31:0] r;
        bus(idx, 1'b1, d, r);
        if (idx == pcd_pkg::IDX_DEV_RANGE) m_range <= int'(d[15:0]);
        if (idx == pcd_pkg::IDX_DELAY_TIME) m_delay <= int'(d[15:0]);
        if (idx == pcd_pkg::IDX_OUT_CTRL) m_nc <= int'(d[0]);
        if (idx == pcd_pkg::IDX_COND_SEL) begin
            m_cond <= int'(d[15:0]);
            m_lat  <= 2;  // Latch state not known across a mode change
        end
    endtask

    task automatic rdchk(input logic [15:0] idx, input logic [31:0] exp,
                         input logic [31:0] mask = 32'hFFFFFFFF);
        logic [31:0] r;
        bus(idx, 1'b0, 32'h0, r);
        chk_word(r & mask, exp);
        chk_bit(hresp, 1'b0);
    endtask

    // Random deviation, speed and command runs
    task automatic run(input int n);
        logic [31:0] r;
        repeat (n) begin
            r = xs();
            if (r[25:24] == 2'h0) dev <= 32'(int'(r[5:0]) - 30);
            spd <= 16'(int'(r[14:8]) - 64);
            if (r[23:19] == 5'h0) cmd <= !cmd;
            @(posedge clk);
        end
    endtask

    ////////////////////////////////////////
    // Reference model, evaluated on the same edges as the design
    always @(posedge clk) begin
        int a, inr, el, lo, hi, nf;
        a = $signed(dev);
        if (a < 0) a = -a;
        inr = (a < m_range);
        cyc = cmd ? 0 : cyc + 1;
        lo = (cyc - 2) / MSC;
        hi = cyc / MSC + 1;
        el = (lo >= m_delay) ? 1 : (hi < m_delay) ? 0 : 2;
        if (cmd) m_lat = 0;
        else if (m_lat != 1 && inr && el != 0) m_lat = el;
        case (m_cond)
            0: nf = inr;
            1: nf = !cmd && inr;
            2: nf = (cmd || !inr) ? 0 : m_zs;
            3: nf = m_lat;
            4: nf = (cmd || !inr) ? 0 : el;
            default: nf = 0;
        endcase
        a = $signed(spd);
        if (a < 0) a = -a;
        if (a < int'(pcd_pkg::RST_ZS_THRESH)) m_zs = 1;
        else if (a >= int'(pcd_pkg::RST_ZS_THRESH + pcd_pkg::ZS_HYST_RPM)) m_zs = 0;
        // Reset clears flag, latch, zero speed and the delay timer
        if (rst) begin
            nf = 0;
            m_lat = 0;
            m_zs = 0;
            cyc = 0;
            m_range = int'(pcd_pkg::RST_DEV_RANGE);
            m_cond = int'(pcd_pkg::RST_COND_SEL);
            m_delay = int'(pcd_pkg::RST_DELAY_TIME);
            m_nc = int'(pcd_pkg::RST_NC_MODE);
        end
        m_pnc = m_nc;
        m_flag = nf;
    end

    // Compare at the falling edge, where outputs have settled
    always @(negedge clk) begin
        if (m_flag != 2) begin
            chk_bit(flag, m_flag[0]);
            chk_bit(seen, m_flag[0]);
        end
        cycles++;
        if (cycles > LIMIT) begin
            failures++;
            results();
        end
    end

    ////////////////////////////////////////
    initial begin
        seed = 32'hA1E37DE6;
        {failures, comparisons, cycles, cyc} = '0;
        {hsel, haddr, htrans, hwrite, hwdata, dev, cmd, spd} = '0;
        rst = 1'b1;
        m_lat = 2;
        m_zs = 0;
        m_flag = 2;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rdchk(pcd_pkg::IDX_DEV_RANGE, 32'h14);
        rdchk(pcd_pkg::IDX_COND_SEL, 32'h1);
        rdchk(pcd_pkg::IDX_DELAY_TIME, 32'h0);
        rdchk(16'h2435, 32'h0);
        wr(pcd_pkg::IDX_DEV_RANGE, 32'hFFFF0010);
        rdchk(pcd_pkg::IDX_DEV_RANGE, 32'h10);
        run(100);
        $display("Test reset values and default condition done");
        for (int nc = 0; nc < 2; nc++) begin
            wr(pcd_pkg::IDX_OUT_CTRL, 32'(nc));
            for (int c = 0; c < 6; c++) begin
                for (int d = 0; d < 4; d += 3) begin
                    wr(pcd_pkg::IDX_COND_SEL, 32'(c));
                    wr(pcd_pkg::IDX_DELAY_TIME, 32'(d));
                    rdchk(pcd_pkg::IDX_DELAY_TIME, 32'(d));
                    run(250);
                    $display("Test nc=%0d cond=%0d delay=%0d done", nc, c, d);
                end
            end
        end
        wr(pcd_pkg::IDX_COND_SEL, 32'h0);
        dev <= 32'h0;
        cmd <= 1'b1;
        repeat (4) @(posedge clk);
        rdchk(pcd_pkg::IDX_STATUS, 32'h5, 32'hFFFFFFFD);
        wr(pcd_pkg::IDX_STATUS, 32'h0);
        rdchk(pcd_pkg::IDX_STATUS, 32'h5, 32'hFFFFFFFD);
        $display("Test status register done");
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rdchk(pcd_pkg::IDX_COND_SEL, 32'h1);
        rdchk(pcd_pkg::IDX_DEV_RANGE, 32'h14);
        run(100);
        $display("Test second reset done");
        results();
    end
endmodule
